//--- src/oasc_onoff_ctrl.sv
// On/off activity state controller: four-state power sequencer with
// register port, wake events, time-out timer and host reset output.
// Assumes pin and comparator flag inputs may be asynchronous to mclk; the register port is used unsynchronised.
//
// Contract
// - Status bits 0..3 show power button and three wake input levels.
// - Status bit 7 is 1 while die temperature is below maximum.
// - Exactly one of unpowered, save, standby, active is held.
// - Unpowered goes to save when supply exceeds minimum threshold.
// - Save drops to unpowered on supply loss with no backup battery, or on backup battery loss.
// - Save enters standby only with system ok and temperature ok.
// - With USB and battery check set, battery ok also required.
// - Standby returns to save on supply, temperature or battery fault.
// - Button falling edge and moded wake input edges wake standby.
// - A blocked edge wake event is discarded, not kept.
// - RTC, USB, adapter wakes are levels held by read-cleared bits.
// - Wake-enable bits gate waking but not event reporting.
// - Active enables supplies, releases host reset after settling.
// - Request bit, host-alive loss, shutdown edge give direct standby.
// - Mode-enabled button or wake input events start 8 s timer.
// - Supply below minimum moves active straight to save.
// - Low system voltage in active starts 8 s timer to save.
// - Over-temperature in active starts 1 s timer to save.
// - Save keeps only internal supplies running and holds pins.
// - Standby runs monitoring and permits the regulators.
// - Host has full register control in active.
`default_nettype none
module oasc_onoff_ctrl
    import oasc_pkg::*;
#(
    parameter int unsigned TO_LONG_CYC    = OASC_TO_LONG_CYC,
    parameter int unsigned TO_SHORT_CYC   = OASC_TO_SHORT_CYC,
    parameter int unsigned ONKEY_HOLD_CYC = OASC_ONKEY_HOLD_CYC,
    parameter int unsigned GRACE_CYC      = OASC_GRACE_CYC,
    parameter int unsigned STAB_CYC       = OASC_STAB_CYC
)
(
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       onkey_in,
    input  wire logic       ext_wake_in_1,
    input  wire logic       ext_wake_in_2,
    input  wire logic       ext_wake_in_3,
    input  wire logic       bubpres_in,
    input  wire logic       sysok_in,
    input  wire logic       batok_in,
    input  wire logic       tmpok_in,
    input  wire logic       sysmin_ok_in,
    input  wire logic       syspres_in,
    input  wire logic       usb_present_in,
    input  wire logic       adapter_sense_in,
    input  wire logic       rtc_alarm_in,
    input  wire logic       shutdown_in,
    input  wire logic       host_alive_in,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    output logic [1:0]      state_out,
    output logic            supplies_on,
    output logic            monitor_on,
    output logic            ldo_allowed,
    output logic            gpio_hold,
    input  wire logic       host_reset_out_i,
    output logic            host_reset_out_o,
    output logic            host_reset_out_oe
);
    typedef logic [OASC_CNT_W-1:0] oasc_cnt_t;
    // Two-stage synchronisers, plus a third stage for edge detection
    logic [OASC_IN_W-1:0] sy1_r, sy2_r, sy3_r;
    wire  [OASC_IN_W-1:0] raw_in = {host_alive_in, shutdown_in, rtc_alarm_in,
        adapter_sense_in, usb_present_in, syspres_in, sysmin_ok_in, tmpok_in,
        batok_in, sysok_in, bubpres_in, ext_wake_in_3, ext_wake_in_2,
        ext_wake_in_1, onkey_in};
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            sy1_r <= '0;
            sy2_r <= '0;
            sy3_r <= '0;
        end
        else
        begin
            sy1_r <= raw_in;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
        end
    end
    wire [OASC_IN_W-1:0] rise = sy2_r & ~sy3_r;
    wire [OASC_IN_W-1:0] fall = ~sy2_r & sy3_r;

    oasc_state_e state_r, state_nxt;
    logic [7:0]  wake_r, mode_r, ctrl_r, evt_r;
    logic        grace_r;
    oasc_cnt_t   grace_cnt_r, stab_cnt_r, hold_cnt_r, to_cnt_r;
    logic        hold_done_r, to_run_r, to_save_r, rst_rel_r;

    // Register port decode; writes only count while active
    wire is_active = (state_r == OASC_ACTIVE);
    wire wr_ok     = reg_wr && is_active;
    wire wr_shdwn  = wr_ok && (reg_addr == OASC_ADDR_SHDWN);
    wire go_stby_w = wr_shdwn && reg_wdata[OASC_SHDWN_GO_STBY];
    wire totrst_w  = wr_shdwn && reg_wdata[OASC_SHDWN_TOTRST];
    wire rd_evt    = reg_rd && (reg_addr == OASC_ADDR_EVENT);

    // Fault-free condition gating save->standby and standby->active
    wire usb_chk   = sy2_r[OASC_IN_USB] && ctrl_r[OASC_CTRL_USBBATCHK];
    wire pwr_good  = sy2_r[OASC_IN_SYSOK] && sy2_r[OASC_IN_TMPOK]
                     && (!usb_chk || sy2_r[OASC_IN_BATOK]);
    wire save_lost = sy2_r[OASC_IN_BUBPRS] ? ~sy2_r[OASC_IN_BUBPRS]
                     : ~sy2_r[OASC_IN_SYSPRS];
    wire bub_lost  = sy3_r[OASC_IN_BUBPRS] & ~sy2_r[OASC_IN_BUBPRS];

    // Edge wake events: button falls, wake inputs on the moded edge
    function automatic logic [2:0] ext_edge(input logic [2:0] r, input logic [2:0] f,
                                            input logic [7:0] m, input logic want_wake);
        logic [2:0] e;
        e = '0;
        for (int i = 0; i < 3; i++)
            e[i] = (m[2*i] ~^ want_wake) ? r[i] : f[i];
        return e;
    endfunction
    wire [2:0] ext_wake_ev = ext_edge(rise[3:1], fall[3:1], mode_r, 1'b1);
    wire [2:0] ext_to_ev   = ext_edge(rise[3:1], fall[3:1], mode_r, 1'b0)
                             & {mode_r[5], mode_r[3], mode_r[1]};
    wire [1:0] onkey_mode  = mode_r[OASC_MODE_ONKEY_LO +: 2];
    wire edge_wake = (fall[OASC_IN_ONKEY] && wake_r[0])
                     || |(ext_wake_ev & wake_r[3:1]);
    // Level wakes hold while their event bits stay set
    wire lvl_wake  = (evt_r[OASC_EVT_RTC] && wake_r[OASC_WAKE_RTC])
                     || (evt_r[OASC_EVT_USB] && wake_r[OASC_WAKE_USB])
                     || (evt_r[OASC_EVT_ADP] && wake_r[OASC_WAKE_ADP]);

    // Time-out sources in active
    wire onkey_hold = (onkey_mode == 2'b01) && !sy2_r[OASC_IN_ONKEY]
                      && !hold_done_r && (hold_cnt_r == oasc_cnt_t'(ONKEY_HOLD_CYC - 1));
    wire stby_to_ev = is_active && (onkey_hold
                      || ((onkey_mode == 2'b10) && rise[OASC_IN_ONKEY])
                      || |ext_to_ev);
    wire lowsys_ev  = fall[OASC_IN_SYSOK];
    wire hightmp_ev = fall[OASC_IN_TMPOK];
    wire to_expired = to_run_r && (to_cnt_r == '0);
    wire direct_stby = (grace_r && grace_cnt_r == '0) || !sy2_r[OASC_IN_KEEPA]
                       || rise[OASC_IN_SHDWN];

    // Next activity state; only four legal codes exist
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            OASC_UNPOWERED:
                if (sy2_r[OASC_IN_SYSMIN]) state_nxt = OASC_SAVE;
            OASC_SAVE:
                if (save_lost || bub_lost) state_nxt = OASC_UNPOWERED;
                else if (pwr_good) state_nxt = OASC_STANDBY;
            OASC_STANDBY:
                if (!pwr_good) state_nxt = OASC_SAVE;
                else if (edge_wake || lvl_wake) state_nxt = OASC_ACTIVE;
            OASC_ACTIVE:
                if (!sy2_r[OASC_IN_SYSMIN]) state_nxt = OASC_SAVE;
                else if (to_expired && to_save_r) state_nxt = OASC_SAVE;
                else if (to_expired || direct_stby) state_nxt = OASC_STANDBY;
        endcase
    end
    // A blocked edge event is not stored anywhere, so it is dropped

    // State, configuration and event registers
    always_ff @(posedge mclk)
    begin
        if (!reset_n || state_r == OASC_UNPOWERED)
        begin
            state_r <= reset_n ? state_nxt : OASC_UNPOWERED;
            wake_r  <= OASC_WAKE_RST;
            mode_r  <= OASC_MODE_RST;
            ctrl_r  <= OASC_CTRL_RST;
            evt_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            if (wr_ok && reg_addr == OASC_ADDR_WAKE) wake_r <= reg_wdata;
            if (wr_ok && reg_addr == OASC_ADDR_MODE) mode_r <= reg_wdata;
            if (wr_ok && reg_addr == OASC_ADDR_CTRL) ctrl_r <= reg_wdata;
            // New events win over the read that clears them
            evt_r <= (rd_evt ? 8'h00 : evt_r) | {3'h0, hightmp_ev, lowsys_ev,
                     rise[OASC_IN_ADP], rise[OASC_IN_USB], rise[OASC_IN_RTC]};
        end
    end

    // Read data; status mirrors synchronised levels
    wire [7:0] rd_mux = (reg_addr == OASC_ADDR_STAT)  ? sy2_r[7:0] :
                        (reg_addr == OASC_ADDR_CTRL)  ? ctrl_r :
                        (reg_addr == OASC_ADDR_MODE)  ? mode_r :
                        (reg_addr == OASC_ADDR_WAKE)  ? wake_r :
                        (reg_addr == OASC_ADDR_EVENT) ? evt_r : 8'h00;
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rd_mux;
    end

    // Go-standby grace and power-button hold counters
    always_ff @(posedge mclk)
    begin
        if (!reset_n || !is_active)
        begin
            grace_r     <= 1'b0;
            grace_cnt_r <= '0;
            hold_cnt_r  <= '0;
            hold_done_r <= 1'b1;   // Button held through wake does not arm
        end
        else
        begin
            if (go_stby_w && !grace_r)
            begin
                grace_r     <= 1'b1;
                grace_cnt_r <= oasc_cnt_t'(GRACE_CYC - 1);
            end
            else if (grace_r && grace_cnt_r != '0)
                grace_cnt_r <= grace_cnt_r - 1'b1;
            if (sy2_r[OASC_IN_ONKEY])
            begin
                hold_cnt_r  <= '0;
                hold_done_r <= 1'b0;
            end
            else if (!hold_done_r)
            begin
                hold_cnt_r  <= hold_cnt_r + 1'b1;
                hold_done_r <= onkey_hold;
            end
        end
    end

    // Time-out timer; host stops it by the timer-reset bit
    always_ff @(posedge mclk)
    begin
        if (!reset_n || !is_active)
        begin
            to_run_r  <= 1'b0;
            to_save_r <= 1'b0;
            to_cnt_r  <= '0;
        end
        else if (hightmp_ev)
        begin
            to_run_r  <= 1'b1;
            to_save_r <= 1'b1;
            to_cnt_r  <= oasc_cnt_t'(TO_SHORT_CYC - 1);
        end
        else if (lowsys_ev || (stby_to_ev && !to_run_r))
        begin
            to_run_r  <= 1'b1;
            to_save_r <= lowsys_ev;
            to_cnt_r  <= oasc_cnt_t'(TO_LONG_CYC - 1);
        end
        else if (totrst_w)
            to_run_r <= 1'b0;      // Host intervened
        else if (to_run_r && to_cnt_r != '0)
            to_cnt_r <= to_cnt_r - 1'b1;
    end

    // Supply settle counter and host reset release
    always_ff @(posedge mclk)
    begin
        if (!reset_n || !is_active)
        begin
            stab_cnt_r <= oasc_cnt_t'(STAB_CYC - 1);
            rst_rel_r  <= 1'b0;
        end
        else if (stab_cnt_r != '0)
            stab_cnt_r <= stab_cnt_r - 1'b1;
        else
            rst_rel_r <= 1'b1;
    end

    // Output flops; reset pin is pulled low whenever not released
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            state_out         <= OASC_UNPOWERED;
            supplies_on       <= 1'b0;
            monitor_on        <= 1'b0;
            ldo_allowed       <= 1'b0;
            gpio_hold         <= 1'b0;
            host_reset_out_o  <= 1'b0;
            host_reset_out_oe <= 1'b1;
        end
        else
        begin
            state_out         <= state_nxt;
            supplies_on       <= state_nxt == OASC_ACTIVE;
            monitor_on        <= state_nxt[1];
            ldo_allowed       <= state_nxt[1];
            gpio_hold         <= state_nxt == OASC_SAVE;
            host_reset_out_o  <= 1'b0;
            host_reset_out_oe <= !(rst_rel_r && state_nxt == OASC_ACTIVE);
        end
    end

    // Checks
    a_unpow_rise: assert property (@(posedge mclk) disable iff (!reset_n)
        state_r == OASC_UNPOWERED && sy2_r[OASC_IN_SYSMIN] |=> state_r == OASC_SAVE)
        else $error("unpowered did not rise to save");
    a_emerg_save: assert property (@(posedge mclk) disable iff (!reset_n)
        is_active && !sy2_r[OASC_IN_SYSMIN] |=> state_r == OASC_SAVE ##0 host_reset_out_oe)
        else $error("emergency save missed");
    a_stby_enter: assert property (@(posedge mclk) disable iff (!reset_n)
        state_r == OASC_SAVE ##1 state_r == OASC_STANDBY |-> $past(pwr_good))
        else $error("standby entered without power good");
    a_stby_fault: assert property (@(posedge mclk) disable iff (!reset_n)
        state_r == OASC_STANDBY && !sy2_r[OASC_IN_SYSOK] |=> state_r == OASC_SAVE)
        else $error("standby fault did not return to save");
    a_key_wake: assert property (@(posedge mclk) disable iff (!reset_n)
        state_r == OASC_STANDBY && pwr_good && fall[OASC_IN_ONKEY] && wake_r[0]
        |=> is_active)
        else $error("button wake missed");
    a_rst_held: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(is_active) |-> host_reset_out_oe [*2])
        else $error("host reset released too early");
    a_status_read: assert property (@(posedge mclk) disable iff (!reset_n)
        reg_rd && reg_addr == OASC_ADDR_STAT |=> reg_rdata == $past(sy2_r[7:0]))
        else $error("status read mismatch");
    a_evt_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_evt && state_r != OASC_UNPOWERED && rise[OASC_IN_RTC]
        |=> evt_r[OASC_EVT_RTC])
        else $error("event lost on clearing read");
    a_shdwn_edge: assert property (@(posedge mclk) disable iff (!reset_n)
        is_active && sy2_r[OASC_IN_SYSMIN] && rise[OASC_IN_SHDWN] && !to_expired
        |=> state_r == OASC_STANDBY)
        else $error("shutdown edge ignored");
    a_hot_timer: assert property (@(posedge mclk) disable iff (!reset_n)
        is_active && hightmp_ev |=> to_run_r && to_save_r)
        else $error("over-temperature timer not started");
endmodule
`default_nettype wire

//--- src/oasc_pkg.sv
// Package for the on/off activity state controller: register map, field
// positions, reset values, state encoding and timing counts.
// Assumes a single 20 MHz clock; long counts are re-exposed as parameters.
`default_nettype none
package oasc_pkg;
    // Register offsets
    localparam logic [7:0] OASC_ADDR_SHDWN   = 8'h0c;
    localparam logic [7:0] OASC_ADDR_WAKE    = 8'h0d;
    localparam logic [7:0] OASC_ADDR_MODE    = 8'h10;
    localparam logic [7:0] OASC_ADDR_CTRL    = 8'h11;
    localparam logic [7:0] OASC_ADDR_STAT    = 8'h12;
    localparam logic [7:0] OASC_ADDR_EVENT   = 8'h13;
    // Reset values (taken when the block is unpowered)
    localparam logic [7:0] OASC_WAKE_RST     = 8'hdf;
    localparam logic [7:0] OASC_MODE_RST     = 8'h00;
    localparam logic [7:0] OASC_CTRL_RST     = 8'h00;
    // Field positions
    localparam int OASC_SHDWN_GO_STBY        = 0;
    localparam int OASC_SHDWN_TOTRST         = 1;
    localparam int OASC_CTRL_USBBATCHK       = 4;
    localparam int OASC_WAKE_RTC             = 4;
    localparam int OASC_WAKE_USB             = 6;
    localparam int OASC_WAKE_ADP             = 7;
    localparam int OASC_MODE_ONKEY_LO        = 6;
    localparam int OASC_EVT_RTC              = 0;
    localparam int OASC_EVT_USB              = 1;
    localparam int OASC_EVT_ADP              = 2;
    localparam int OASC_EVT_LOWSYS           = 3;
    localparam int OASC_EVT_HIGHTMP          = 4;
    // Synchronised input vector positions
    localparam int OASC_IN_ONKEY  = 0;
    localparam int OASC_IN_EXT1   = 1;
    localparam int OASC_IN_BUBPRS = 4;
    localparam int OASC_IN_SYSOK  = 5;
    localparam int OASC_IN_BATOK  = 6;
    localparam int OASC_IN_TMPOK  = 7;
    localparam int OASC_IN_SYSMIN = 8;
    localparam int OASC_IN_SYSPRS = 9;
    localparam int OASC_IN_USB    = 10;
    localparam int OASC_IN_ADP    = 11;
    localparam int OASC_IN_RTC    = 12;
    localparam int OASC_IN_SHDWN  = 13;
    localparam int OASC_IN_KEEPA  = 14;
    localparam int OASC_IN_W      = 15;
    // Timing
    localparam int unsigned OASC_CLK_HZ      = 20_000_000;
    localparam int unsigned OASC_TO_LONG_S   = 8;
    localparam int unsigned OASC_TO_SHORT_S  = 1;
    localparam int unsigned OASC_ONKEY_HOLD_S = 1;
    localparam int unsigned OASC_GRACE_MS    = 2;
    localparam int unsigned OASC_STAB_MS     = 10;
    localparam int unsigned OASC_TO_LONG_CYC   = OASC_TO_LONG_S * OASC_CLK_HZ;
    localparam int unsigned OASC_TO_SHORT_CYC  = OASC_TO_SHORT_S * OASC_CLK_HZ;
    localparam int unsigned OASC_ONKEY_HOLD_CYC = OASC_ONKEY_HOLD_S * OASC_CLK_HZ;
    localparam int unsigned OASC_GRACE_CYC   = OASC_GRACE_MS * (OASC_CLK_HZ / 1000);
    localparam int unsigned OASC_STAB_CYC    = OASC_STAB_MS * (OASC_CLK_HZ / 1000);
    localparam int OASC_CNT_W = 28;
    // Activity states
    typedef enum logic [1:0] {
        OASC_UNPOWERED = 2'b00,
        OASC_SAVE      = 2'b01,
        OASC_STANDBY   = 2'b10,
        OASC_ACTIVE    = 2'b11
    } oasc_state_e;
endpackage
`default_nettype wire

//--- verification/oasc_host_model.sv
// Host controller model: master of the register port.
// Assumes the controller takes requests on the rising mclk edge.
`default_nettype none
module oasc_host_model
    import oasc_pkg::*;
(
    input  wire logic       mclk,
    output var logic [7:0]  reg_addr,
    output var logic        reg_wr,
    output var logic [7:0]  reg_wdata,
    output var logic        reg_rd,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle port at time zero, no strobe raised
    initial
    begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end

    // One write; dropped by the controller outside active
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= dat;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // One read; data taken mid-cycle after the answering edge
    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(negedge mclk);
        dat = reg_rdata;
    endtask
endmodule
`default_nettype wire

//--- verification/oasc_onoff_ctrl_test.sv
// Self-checking bench for the on/off activity state controller.
// Assumes short timer parameters; the host model drives the register port.
`default_nettype none
module oasc_onoff_ctrl_test
    import oasc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TLONG = 200;
    localparam int TSHORT = 50;
    localparam int GRACE = 10;
    localparam int STAB = 8;
    logic       mclk, rst_n, onkey, e1, e2, e3, bub, sok, bok, tok;
    logic       smin, spres, usb, adp, rtc, shdn, alive, rwr, rrd;
    logic       sup, mon, ldo, hold, rst_o, rst_oe;
    logic [7:0] raddr, rwdata, rdata, d, v;
    logic [1:0] st;
    int         failures, check_count, i, n;
    int         seed = 88;
    // Open-drain host reset with its pull-up
    wire        rst_line = rst_oe ? rst_o : 1'b1;

    oasc_onoff_ctrl #(.TO_LONG_CYC(TLONG), .TO_SHORT_CYC(TSHORT), .ONKEY_HOLD_CYC(30),
        .GRACE_CYC(GRACE), .STAB_CYC(STAB)) oasc_onoff_ctrl_i (
        .mclk(mclk), .reset_n(rst_n), .onkey_in(onkey), .ext_wake_in_1(e1),
        .ext_wake_in_2(e2), .ext_wake_in_3(e3), .bubpres_in(bub), .sysok_in(sok),
        .batok_in(bok), .tmpok_in(tok), .sysmin_ok_in(smin), .syspres_in(spres),
        .usb_present_in(usb), .adapter_sense_in(adp), .rtc_alarm_in(rtc),
        .shutdown_in(shdn), .host_alive_in(alive), .reg_addr(raddr), .reg_wr(rwr),
        .reg_wdata(rwdata), .reg_rd(rrd), .reg_rdata(rdata), .state_out(st),
        .supplies_on(sup), .monitor_on(mon), .ldo_allowed(ldo), .gpio_hold(hold),
        .host_reset_out_i(rst_line), .host_reset_out_o(rst_o), .host_reset_out_oe(rst_oe));

    oasc_host_model oasc_host_model_i (.mclk(mclk), .reg_addr(raddr), .reg_wr(rwr),
        .reg_wdata(rwdata), .reg_rd(rrd), .reg_rdata(rdata));

    // Free-running 20 MHz clock
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    task automatic ck(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Bounded wait for a state, then compare it
    task automatic wait_st(input logic [1:0] s, input int lim);
        int k;
        for (k = 0; k < lim && st !== s; k++)
            @(negedge mclk);
        ck("state", {6'h0, s}, {6'h0, st});
    endtask

    // Button press from standby; host reset must stay low until supplies settle
    task automatic wake();
        int k;
        @(posedge mclk);
        onkey <= 1'b1;
        repeat (4) @(posedge mclk);
        onkey <= 1'b0;
        wait_st(2'h3, 8);
        ck("rst_entry", 8'h00, {7'h0, rst_line});
        for (k = 0; k < STAB + 6 && rst_line !== 1'b1; k++)
            @(negedge mclk);
        ck("rst_free", 8'h03, {6'h0, rst_line, sup});
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog; the whole sequence needs a little over a thousand cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        final_report();
    end

    // Main sequence: one trip through every state and transition kind
    initial
    begin
        rst_n = 1'b0;
        {onkey, e1, e2, e3, bub, sok, bok, tok, smin, spres} = 10'h200;
        {usb, adp, rtc, shdn, alive} = 5'h01;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        ck("reset", 8'h01, {5'h0, st, rst_oe});
        for (i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            v = 8'($random(seed));
            {tok, bok, sok, bub, e3, e2, e1, onkey} <= v;
            repeat (4) @(posedge mclk);
            oasc_host_model_i.rd(OASC_ADDR_STAT, d);
            ck("status", v, d);
        end
        @(posedge mclk);
        {tok, bok, sok, bub, e3, e2, e1, onkey} <= 8'h01;
        oasc_host_model_i.rd(8'h20, d);
        ck("unmapped", 8'h00, d);
        @(posedge mclk);
        smin <= 1'b1;
        spres <= 1'b1;
        wait_st(2'h1, 6);
        ck("gpio_hold", 8'h01, {7'h0, hold});
        @(posedge mclk);
        sok <= 1'b1;
        onkey <= 1'b0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        ck("hot_save", 8'h01, {6'h0, st});
        @(posedge mclk);
        tok <= 1'b1;
        wait_st(2'h2, 6);
        ck("standby_on", 8'h03, {6'h0, mon, ldo});
        oasc_host_model_i.wr(OASC_ADDR_CTRL, 8'h10);
        oasc_host_model_i.rd(OASC_ADDR_CTRL, d);
        ck("ctrl_refused", 8'h00, d);
        ck("edge_dropped", 8'h02, {6'h0, st});
        wake();
        oasc_host_model_i.wr(OASC_ADDR_CTRL, 8'h10);
        oasc_host_model_i.rd(OASC_ADDR_CTRL, d);
        ck("ctrl", 8'h10, d);
        @(posedge mclk);
        usb <= 1'b1;
        repeat (5) @(posedge mclk);
        oasc_host_model_i.rd(OASC_ADDR_EVENT, d);
        ck("evt_usb", 8'h02, d & 8'h02);
        oasc_host_model_i.rd(OASC_ADDR_EVENT, d);
        ck("evt_clear", 8'h00, d & 8'h02);
        oasc_host_model_i.wr(OASC_ADDR_SHDWN, 8'h01);
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        ck("grace", 8'h03, {6'h0, st});
        wait_st(2'h2, GRACE + 8);
        wait_st(2'h1, 8);
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        ck("batt_block", 8'h01, {6'h0, st});
        @(posedge mclk);
        bok <= 1'b1;
        wait_st(2'h2, 6);
        @(posedge mclk);
        rtc <= 1'b1;
        wait_st(2'h3, 8);
        oasc_host_model_i.rd(OASC_ADDR_EVENT, d);
        oasc_host_model_i.wr(OASC_ADDR_WAKE, 8'hcf);
        oasc_host_model_i.wr(OASC_ADDR_SHDWN, 8'h01);
        wait_st(2'h2, GRACE + 8);
        @(posedge mclk);
        rtc <= 1'b0;
        repeat (4) @(posedge mclk);
        rtc <= 1'b1;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        ck("rtc_masked", 8'h02, {6'h0, st});
        oasc_host_model_i.rd(OASC_ADDR_EVENT, d);
        ck("evt_rtc", 8'h01, d & 8'h01);
        wake();
        @(posedge mclk);
        shdn <= 1'b1;
        wait_st(2'h2, 8);
        @(posedge mclk);
        shdn <= 1'b0;
        wake();
        @(posedge mclk);
        alive <= 1'b0;
        wait_st(2'h2, 8);
        @(posedge mclk);
        alive <= 1'b1;
        wake();
        // Low supply then over-temperature: long then short time-out to save
        for (i = 0; i < 2; i++)
        begin
            n = (i == 0) ? TLONG : TSHORT;
            @(posedge mclk);
            if (i == 0)
                sok <= 1'b0;
            else
                tok <= 1'b0;
            repeat (n - 20) @(posedge mclk);
            @(negedge mclk);
            ck("timer_run", 8'h03, {6'h0, st});
            wait_st(2'h1, 30);
            @(posedge mclk);
            sok <= 1'b1;
            tok <= 1'b1;
            wait_st(2'h2, 8);
            wake();
        end
        oasc_host_model_i.wr(OASC_ADDR_MODE, 8'h83);
        @(posedge mclk);
        onkey <= 1'b1;
        repeat (TLONG - 20) @(posedge mclk);
        @(negedge mclk);
        ck("key_timer", 8'h03, {6'h0, st});
        wait_st(2'h2, 30);
        // Wake input 1 in mode 11: rising edge wakes, falling edge arms the timer
        @(posedge mclk);
        e1 <= 1'b1;
        wait_st(2'h3, 8);
        @(posedge mclk);
        e1 <= 1'b0;
        repeat (TLONG - 20) @(posedge mclk);
        @(negedge mclk);
        ck("ext_timer", 8'h03, {6'h0, st});
        wait_st(2'h2, 30);
        wake();
        // Button mode 01: held low past the hold time arms the long timer
        oasc_host_model_i.wr(OASC_ADDR_MODE, 8'h43);
        @(posedge mclk);
        onkey <= 1'b1;
        repeat (4) @(posedge mclk);
        onkey <= 1'b0;
        repeat (TLONG) @(posedge mclk);
        @(negedge mclk);
        ck("hold_timer", 8'h03, {6'h0, st});
        wait_st(2'h2, 60);
        wake();
        @(posedge mclk);
        smin <= 1'b0;
        sok <= 1'b0;
        wait_st(2'h1, 6);
        ck("rst_emerg", 8'h00, {7'h0, rst_line});
        @(posedge mclk);
        spres <= 1'b0;
        bub <= 1'b1;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        ck("backup", 8'h01, {6'h0, st});
        @(posedge mclk);
        bub <= 1'b0;
        wait_st(2'h0, 6);
        oasc_host_model_i.rd(OASC_ADDR_WAKE, d);
        ck("wake_reset", OASC_WAKE_RST, d);
        final_report();
    end
endmodule
`default_nettype wire
